// file: hdl/ppecp_regs.svh
// Notes on behaviour
// - Mode 000 resets the FIFO, control lines open-collector, data always driven.
// - Mode 001 direction tri-states data; data reads return live pins; others push-pull.
// - Mode 010 sends FIFO bytes with the compatibility strobe handshake, forward only.
// - Mode 011 forward: address and data queue bytes share one FIFO, ECP handshake.
// - Mode 110 FIFO is host read/write only, never sent on the port.
// - Mode 111 maps the two configuration words at 0x400 and 0x401.
// - Fault irq disable bit, ECP only: when 0, fault falling edge pulses interrupt.
// - Clearing fault irq disable while fault is asserted interrupts at once.
// - DMA permit bit enables requests only while service mask is 0.
// - Service mask blocks DMA and service interrupts; hardware sets it on each service interrupt.
// - With DMA on, terminal count sets the service mask.
// - Without DMA, free or stored bytes reaching service level set the mask.
// - Read-only full and empty flags track the FIFO.
// - Any mode from 000/001; else only to 000/001; direction changes only in 001.
// - Modes 010 and 011 alone run the automatic handshake.
// - Control outputs leave the handshake on the same edge a switch back to 000 or 001 applies.
// - Leaving ECP reverse discards FIFO bytes and releases autofeed cleanly.
// - ECP reverse: one handshake per byte while the FIFO has room.
// - ECP forward: data with HostAck high, commands with HostAck low.
// - All FIFO modes share one 16-byte FIFO.
// - Direction 0 out, 1 in, except modes 000 and 010 which always drive.
// - Service interrupt is a brief low pulse, then the line is released.
`ifndef PPECP_REGS_SVH
`define PPECP_REGS_SVH
`define PPECP_OFS_DATA     11'h000
`define PPECP_OFS_STATUS   11'h001
`define PPECP_OFS_CONTROL  11'h002
`define PPECP_OFS_FIFO     11'h400
`define PPECP_OFS_CFGB     11'h401
`define PPECP_OFS_ECR      11'h402
`define PPECP_FIFO_DEPTH   16
`define PPECP_CFGA_VALUE   8'h10
`define PPECP_ECR_RESET    8'h15
`define PPECP_ECR_MODE_LSB 5
`define PPECP_ECR_FAULT    4
`define PPECP_ECR_DMA      3
`define PPECP_ECR_SVC      2
`define PPECP_DCR_DIR      5
`define PPECP_CLK_MHZ      250
`define PPECP_SETUP_NS     500
`define PPECP_STROBE_NS    500
`define PPECP_IRQ_NS       100
`define PPECP_SETUP_CYC    ((`PPECP_SETUP_NS * `PPECP_CLK_MHZ + 999) / 1000)
`define PPECP_STROBE_CYC   ((`PPECP_STROBE_NS * `PPECP_CLK_MHZ + 999) / 1000)
`define PPECP_IRQ_CYC      ((`PPECP_IRQ_NS * `PPECP_CLK_MHZ) / 1000)
`endif

// file: hdl/ppecp_pkg.sv
package ppecp_pkg;
   typedef enum logic [2:0] {
      PPECP_MODE_STD  = 3'b000,
      PPECP_MODE_BIDI = 3'b001,
      PPECP_MODE_CFIFO= 3'b010,
      PPECP_MODE_ECP  = 3'b011,
      PPECP_MODE_EPP  = 3'b100,
      PPECP_MODE_RSVD = 3'b101,
      PPECP_MODE_TEST = 3'b110,
      PPECP_MODE_CFG  = 3'b111
   } ppecp_mode_t;

   typedef enum logic [2:0] {
      PPECP_HS_IDLE     = 3'b000,
      PPECP_HS_SETUP    = 3'b001,
      PPECP_HS_STROBE   = 3'b010,
      PPECP_HS_WAIT_ACK = 3'b011,
      PPECP_HS_WAIT_REL = 3'b100,
      PPECP_HS_REV_REQ  = 3'b101,
      PPECP_HS_REV_REL  = 3'b110
   } ppecp_hs_t;
endpackage

// file: hdl/ppecp_fifo.sv
`timescale 1ns/100ps
`include "ppecp_regs.svh"
module ppecp_fifo
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       clear_in,
   // Fill side
   input  wire logic       push_in,
   input  wire logic [8:0] push_data_in,
   // Drain side
   input  wire logic       pop_in,
   output logic      [8:0] head_out,
   // State
   output logic      [4:0] count_out,
   output logic            full_out,
   output logic            empty_out
);
   logic [8:0] mem [0:`PPECP_FIFO_DEPTH-1];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic [8:0] last;
   logic       do_push;
   logic       do_pop;

   // A write to a full FIFO is dropped; a read of an empty one repeats the last byte
   assign do_push   = push_in && !full_out;
   assign do_pop    = pop_in && !empty_out;
   assign full_out  = (count_out == 5'(`PPECP_FIFO_DEPTH));
   assign empty_out = (count_out == 5'h00);
   assign head_out  = empty_out ? last : mem[rd_ptr];

   always_ff @(posedge sys_clk_in)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= push_data_in;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || clear_in)
      begin
         wr_ptr    <= 4'h0;
         rd_ptr    <= 4'h0;
         count_out <= 5'h00;
      end
      else
      begin
         wr_ptr    <= wr_ptr + 4'(do_push);
         rd_ptr    <= rd_ptr + 4'(do_pop);
         count_out <= count_out + 5'(do_push) - 5'(do_pop);
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         last <= 9'h000;
      end
      else if (do_pop)
      begin
         last <= mem[rd_ptr];
      end
   end
endmodule

// file: hdl/ppecp_port.sv
`timescale 1ns/100ps
`include "ppecp_regs.svh"
module ppecp_port
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   // Host I/O bus pins
   input  wire logic       io_cs_n_in,
   input  wire logic       io_a10_in,
   input  wire logic [1:0] io_addr_in,
   input  wire logic       io_rd_n_in,
   input  wire logic       io_wr_n_in,
   input  wire logic [7:0] io_data_in,
   output logic      [7:0] io_data_out,
   output logic            io_data_oe_out,
   // DMA pins
   input  wire logic       dma_ack_n_in,
   input  wire logic       dma_tc_in,
   output logic            dma_req_out,
   // Service interrupt line
   output logic            irq_out,
   output logic            irq_oe_out,
   // Configuration inputs
   input  wire logic [3:0] fifo_threshold_in,
   // Printer data lines
   input  wire logic [7:0] pd_in,
   output logic      [7:0] pd_out,
   output logic            pd_oe_out,
   // Printer control lines
   output logic            strobe_out_n,
   output logic            strobe_oe_out,
   output logic            autofeed_out_n,
   output logic            autofeed_oe_out,
   output logic            init_out_n,
   output logic            init_oe_out,
   output logic            select_in_out_n,
   output logic            select_in_oe_out,
   // Printer status lines
   input  wire logic       busy_in,
   input  wire logic       ack_in_n,
   input  wire logic       fault_in_n,
   input  wire logic       select_in,
   input  wire logic       perror_in
);
   import ppecp_pkg::*;

   localparam int SYNC_W = 29;

   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic        s_cs_n, s_a10, s_rd_n, s_wr_n, s_dack_n, s_tc;
   logic        s_busy, s_ack_n, s_fault_n, s_select, s_perror;
   logic [1:0]  s_addr;
   logic [7:0]  s_data, s_pd;
   logic        rd_n_d, wr_n_d, fault_n_d, ack_n_d;
   logic        rd_end, wr_end, host_sel, dma_cyc;
   logic [10:0] ofs;
   ppecp_mode_t mode;
   ppecp_mode_t pend_mode;
   logic        pend;
   logic [7:0]  data_reg;
   logic [5:0]  dcr;
   logic [5:0]  cfgb;
   logic        fault_dis_n, dma_permit, service_mask;
   ppecp_hs_t   hs;
   logic [7:0]  hs_cnt;
   logic [8:0]  out_byte;
   logic        hs_strobe_n, hs_afd_n;
   logic [4:0]  irq_cnt;
   logic        fifo_clear, fifo_push, fifo_pop, fifo_full, fifo_empty;
   logic [8:0]  fifo_in, fifo_head;
   logic [4:0]  fifo_count;
   logic [4:0]  level;
   logic        fifo_mode, xfer_mode, dir_in, ecp_rev;
   logic        host_fifo_wr, host_fifo_rd, host_addr_wr;
   logic        svc_event, fault_event, ack_event, fault_clear_event, tc_event;
   logic        ecr_wr, mode_ok;
   logic [7:0]  next_rd_data;

   function automatic logic mode_is_base(input ppecp_mode_t m);
      mode_is_base = (m == PPECP_MODE_STD) || (m == PPECP_MODE_BIDI);
   endfunction

   // Every input pin except rst_in and fifo_threshold_in crosses two flops before use
   always_ff @(posedge sys_clk_in)
   begin
      sync1 <= {io_cs_n_in, io_a10_in, io_addr_in, io_rd_n_in, io_wr_n_in, io_data_in,
                dma_ack_n_in, dma_tc_in, busy_in, ack_in_n, fault_in_n, select_in,
                perror_in, pd_in};
      sync2 <= sync1;
   end

   assign {s_cs_n, s_a10, s_addr, s_rd_n, s_wr_n, s_data, s_dack_n, s_tc,
           s_busy, s_ack_n, s_fault_n, s_select, s_perror, s_pd} = sync2;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         rd_n_d    <= 1'b1;
         wr_n_d    <= 1'b1;
         fault_n_d <= 1'b1;
         ack_n_d   <= 1'b1;
      end
      else
      begin
         rd_n_d    <= s_rd_n;
         wr_n_d    <= s_wr_n;
         fault_n_d <= s_fault_n;
         ack_n_d   <= s_ack_n;
      end
   end

   // Accesses complete on the trailing edge of the strobe
   assign rd_end    = s_rd_n && !rd_n_d;
   assign wr_end    = s_wr_n && !wr_n_d;
   assign dma_cyc   = !s_dack_n;
   assign host_sel  = !s_cs_n && s_dack_n;
   assign ofs       = {s_a10, 8'h00, s_addr};
   assign fifo_mode = (mode == PPECP_MODE_CFIFO) || (mode == PPECP_MODE_ECP) ||
                      (mode == PPECP_MODE_TEST);
   assign xfer_mode = (mode == PPECP_MODE_CFIFO) || (mode == PPECP_MODE_ECP);
   assign dir_in    = dcr[`PPECP_DCR_DIR] && (mode != PPECP_MODE_STD) &&
                      (mode != PPECP_MODE_CFIFO);
   assign ecp_rev   = (mode == PPECP_MODE_ECP) && dir_in;
   assign ecr_wr    = wr_end && host_sel && (ofs == `PPECP_OFS_ECR);

   assign host_fifo_wr = wr_end && fifo_mode && !(xfer_mode && dir_in) &&
                         (dma_cyc || (host_sel && ofs == `PPECP_OFS_FIFO));
   assign host_addr_wr = wr_end && host_sel && (mode == PPECP_MODE_ECP) && !dir_in &&
                         (ofs == `PPECP_OFS_DATA);
   assign host_fifo_rd = rd_end && fifo_mode &&
                         (dma_cyc || (host_sel && ofs == `PPECP_OFS_FIFO));

   // Bit 8 of a FIFO word marks a command byte
   assign fifo_push = host_fifo_wr || host_addr_wr ||
                      (hs == PPECP_HS_REV_REQ && !s_ack_n);
   assign fifo_in   = (hs == PPECP_HS_REV_REQ) ? {!s_busy, s_pd} :
                      {host_addr_wr, s_data};
   assign fifo_pop  = host_fifo_rd || (hs == PPECP_HS_IDLE && xfer_mode && !dir_in &&
                      !pend && !fifo_empty);
   assign fifo_clear = (mode == PPECP_MODE_STD) ||
                       (pend && mode == PPECP_MODE_ECP && dir_in);

   ppecp_fifo u_fifo
   (
      .sys_clk_in   (sys_clk_in),
      .rst_in       (rst_in),
      .clear_in     (fifo_clear),
      .push_in      (fifo_push),
      .push_data_in (fifo_in),
      .pop_in       (fifo_pop),
      .head_out     (fifo_head),
      .count_out    (fifo_count),
      .full_out     (fifo_full),
      .empty_out    (fifo_empty)
   );

   // Mode switches outside the base modes go back only to a base mode
   assign mode_ok = mode_is_base(mode) ||
                    mode_is_base(ppecp_mode_t'(s_data[7:`PPECP_ECR_MODE_LSB]));

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         mode      <= PPECP_MODE_STD;
         pend_mode <= PPECP_MODE_STD;
         pend      <= 1'b0;
      end
      else if (pend)
      begin
         mode <= pend_mode;
         pend <= 1'b0;
      end
      else if (ecr_wr && mode_ok)
      begin
         // Leaving a transfer mode waits one cycle; strobe and autofeed leave the handshake on the edge the mode switches
         if (xfer_mode)
         begin
            pend_mode <= ppecp_mode_t'(s_data[7:`PPECP_ECR_MODE_LSB]);
            pend      <= 1'b1;
         end
         else
         begin
            mode <= ppecp_mode_t'(s_data[7:`PPECP_ECR_MODE_LSB]);
         end
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         data_reg <= 8'h00;
         dcr      <= 6'h00;
         cfgb     <= 6'h00;
      end
      else if (wr_end && host_sel)
      begin
         if (ofs == `PPECP_OFS_DATA && !host_addr_wr)
         begin
            data_reg <= s_data;
         end
         if (ofs == `PPECP_OFS_CONTROL)
         begin
            dcr[4:0] <= s_data[4:0];
            if (mode == PPECP_MODE_BIDI)
            begin
               dcr[`PPECP_DCR_DIR] <= s_data[`PPECP_DCR_DIR];
            end
         end
         if (ofs == `PPECP_OFS_CFGB && mode == PPECP_MODE_CFG)
         begin
            cfgb <= s_data[5:0];
         end
      end
   end

   // Interrupt causes; the service one fires only while the service mask is clear
   assign level       = 5'(fifo_threshold_in) + 5'h01;
   assign tc_event    = dma_permit && dma_cyc && s_tc && (rd_end || wr_end);
   assign svc_event   = !service_mask && fifo_mode &&
                        (dma_permit ? tc_event :
                         (dir_in ? (fifo_count >= level) :
                          (5'(`PPECP_FIFO_DEPTH) - fifo_count >= level)));
   assign fault_clear_event = ecr_wr && fault_dis_n && !s_data[`PPECP_ECR_FAULT] &&
                              !s_fault_n && (mode == PPECP_MODE_ECP);
   assign fault_event = ((mode == PPECP_MODE_ECP) && !fault_dis_n && !s_fault_n &&
                         fault_n_d) || fault_clear_event;
   assign ack_event   = dcr[4] && s_ack_n && !ack_n_d;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         fault_dis_n  <= 1'b1;
         dma_permit   <= 1'b0;
         service_mask <= 1'b1;
      end
      else
      begin
         if (ecr_wr)
         begin
            fault_dis_n <= s_data[`PPECP_ECR_FAULT];
            dma_permit  <= s_data[`PPECP_ECR_DMA];
         end
         // Hardware set wins over a software clear in the same cycle
         if (svc_event)
         begin
            service_mask <= 1'b1;
         end
         else if (ecr_wr)
         begin
            service_mask <= s_data[`PPECP_ECR_SVC];
         end
      end
   end

   // Shared-line pulse: driven low for a short time, then released
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         irq_cnt <= 5'h00;
      end
      else if (svc_event || fault_event || ack_event)
      begin
         irq_cnt <= 5'(`PPECP_IRQ_CYC);
      end
      else if (irq_cnt != 5'h00)
      begin
         irq_cnt <= irq_cnt - 5'h01;
      end
   end

   assign irq_out    = 1'b0;
   assign irq_oe_out = (irq_cnt != 5'h00);

   assign dma_req_out = dma_permit && !service_mask && fifo_mode && !pend &&
                        (dir_in ? !fifo_empty : !fifo_full);

   // Automatic handshake; aborted at once by a pending mode switch
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || pend || !xfer_mode)
      begin
         hs       <= PPECP_HS_IDLE;
         hs_cnt   <= 8'h00;
         out_byte <= 9'h000;
      end
      else
      begin
         unique case (hs)
            PPECP_HS_IDLE:
            begin
               if (ecp_rev && !fifo_full)
               begin
                  hs <= PPECP_HS_REV_REQ;
               end
               else if (!dir_in && !fifo_empty)
               begin
                  out_byte <= fifo_head;
                  hs_cnt   <= 8'(`PPECP_SETUP_CYC);
                  hs       <= PPECP_HS_SETUP;
               end
            end
            PPECP_HS_SETUP:
            begin
               if (hs_cnt == 8'h00)
               begin
                  hs_cnt <= 8'(`PPECP_STROBE_CYC);
                  hs     <= (mode == PPECP_MODE_ECP) ? PPECP_HS_WAIT_ACK : PPECP_HS_STROBE;
               end
               else
               begin
                  hs_cnt <= hs_cnt - 8'h01;
               end
            end
            PPECP_HS_STROBE:
            begin
               if (hs_cnt == 8'h00)
               begin
                  hs <= PPECP_HS_WAIT_REL;
               end
               else
               begin
                  hs_cnt <= hs_cnt - 8'h01;
               end
            end
            PPECP_HS_WAIT_ACK:
            begin
               if (s_busy)
               begin
                  hs <= PPECP_HS_WAIT_REL;
               end
            end
            PPECP_HS_WAIT_REL:
            begin
               if (!s_busy)
               begin
                  hs <= PPECP_HS_IDLE;
               end
            end
            PPECP_HS_REV_REQ:
            begin
               if (!s_ack_n)
               begin
                  hs <= PPECP_HS_REV_REL;
               end
            end
            PPECP_HS_REV_REL:
            begin
               if (s_ack_n)
               begin
                  hs <= PPECP_HS_IDLE;
               end
            end
            default:
            begin
               hs <= PPECP_HS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || pend || !xfer_mode)
      begin
         hs_strobe_n <= 1'b1;
         hs_afd_n    <= 1'b1;
      end
      else
      begin
         hs_strobe_n <= !(hs == PPECP_HS_STROBE || hs == PPECP_HS_WAIT_ACK);
         if (mode == PPECP_MODE_ECP && !dir_in)
         begin
            hs_afd_n <= !out_byte[8];
         end
         else
         begin
            hs_afd_n <= !(hs == PPECP_HS_REV_REQ);
         end
      end
   end

   // Open-collector control lines in mode 000: drive only a low
   always_comb
   begin
      strobe_out_n    = xfer_mode ? hs_strobe_n : !dcr[0];
      autofeed_out_n  = xfer_mode ? hs_afd_n : !dcr[1];
      init_out_n      = dcr[2];
      select_in_out_n = !dcr[3];
      if (mode == PPECP_MODE_STD)
      begin
         strobe_oe_out    = !strobe_out_n;
         autofeed_oe_out  = !autofeed_out_n;
         init_oe_out      = !init_out_n;
         select_in_oe_out = !select_in_out_n;
      end
      else
      begin
         strobe_oe_out    = 1'b1;
         autofeed_oe_out  = 1'b1;
         init_oe_out      = 1'b1;
         select_in_oe_out = 1'b1;
      end
   end

   // Data lines; test mode shows the data register, never FIFO data, and strobes only from control bit 0
   assign pd_out    = xfer_mode ? out_byte[7:0] : data_reg;
   assign pd_oe_out = !dir_in;

   always_comb
   begin
      next_rd_data = 8'h00;
      if (dma_cyc || (host_sel && ofs == `PPECP_OFS_FIFO && mode != PPECP_MODE_CFG))
      begin
         next_rd_data = fifo_head[7:0];
      end
      else if (host_sel)
      begin
         unique case (ofs)
            `PPECP_OFS_DATA:    next_rd_data = (mode == PPECP_MODE_STD) ? data_reg : s_pd;
            `PPECP_OFS_STATUS:  next_rd_data = {!s_busy, s_ack_n, s_perror, s_select,
                                                s_fault_n, 3'h0};
            `PPECP_OFS_CONTROL: next_rd_data = {2'h0, dcr};
            `PPECP_OFS_FIFO:    next_rd_data = `PPECP_CFGA_VALUE;
            `PPECP_OFS_CFGB:    next_rd_data = (mode == PPECP_MODE_CFG) ?
                                               {1'b0, irq_oe_out, cfgb} : 8'h00;
            `PPECP_OFS_ECR:     next_rd_data = {mode, fault_dis_n, dma_permit, service_mask,
                                                fifo_full, fifo_empty};
            default:            next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         io_data_out <= 8'h00;
      end
      else if (!s_rd_n)
      begin
         io_data_out <= next_rd_data;
      end
   end

   assign io_data_oe_out = !s_rd_n && !rd_n_d && (host_sel || dma_cyc);
endmodule

// file: dv/ppecp_props.sv
`timescale 1ns/100ps
module ppecp_props
(
   // Watched ports
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       irq_out,
   input wire logic       irq_oe_out,
   input wire logic       dma_req_out,
   input wire logic [7:0] pd_out,
   input wire logic       pd_oe_out,
   input wire logic       strobe_out_n,
   input wire logic       strobe_oe_out,
   input wire logic       autofeed_out_n,
   input wire logic       autofeed_oe_out,
   input wire logic       ack_in_n
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   property p_oc_stb; !strobe_oe_out |-> strobe_out_n; endproperty
   a_oc_stb: assert property (p_oc_stb) else $error("strobe floats low");
   property p_oc_afd; !autofeed_oe_out |-> autofeed_out_n; endproperty
   a_oc_afd: assert property (p_oc_afd) else $error("autofeed floats low");
   // Own disable so the reset cycles themselves are checked
   property p_rst; disable iff (1'h0) rst_in |=> !irq_oe_out && !dma_req_out; endproperty
   a_rst: assert property (p_rst) else $error("event after reset");
   property p_irq; $rose(irq_oe_out) |-> (irq_oe_out && !irq_out)[*8] ##[1:30] !irq_oe_out;
   endproperty
   a_irq: assert property (p_irq) else $error("bad irq pulse");
   property p_hold; !strobe_out_n && $past(!strobe_out_n) |-> $stable(pd_out); endproperty
   a_hold: assert property (p_hold) else $error("data moved in strobe");
   property p_drv; !strobe_out_n |-> pd_oe_out; endproperty
   a_drv: assert property (p_drv) else $error("strobe on undriven data");
   property p_stb; $fell(strobe_out_n) |-> ##[1:300] strobe_out_n; endproperty
   a_stb: assert property (p_stb) else $error("strobe stuck");
   property p_rev; $fell(ack_in_n) && !autofeed_out_n |-> ##[1:12] autofeed_out_n; endproperty
   a_rev: assert property (p_rev) else $error("no reverse ack");
endmodule
bind ppecp_port ppecp_props i_props (.*);

// file: dv/ppecp_printer.sv
`timescale 1ns/100ps
module ppecp_printer
(
   // Host side lines
   input  wire logic       sys_clk_in,
   input  wire logic       rev_in,
   input  wire logic [7:0] pd_out,
   input  wire logic       pd_oe_out,
   input  wire logic       strobe_out_n,
   input  wire logic       autofeed_out_n,
   // Peripheral lines
   output logic            busy_in,
   output logic            ack_in_n,
   output logic      [7:0] pd_in
);
   logic [8:0] got[$];
   logic [7:0] nxt = 8'ha0;
   initial
   begin
      busy_in = 1'h0;
      ack_in_n = 1'h1;
      pd_in = 8'h00;
   end
   always @(posedge sys_clk_in)
   begin
      if (!rev_in)
      begin
         if (!strobe_out_n && !busy_in)
         begin
            got.push_back({autofeed_out_n, pd_out});
            busy_in <= 1'h1;
         end
         else if (strobe_out_n)
            busy_in <= 1'h0;
         // Undriven lines drift, so never echo a stale byte
         pd_in <= pd_oe_out ? pd_out : ~pd_in;
      end
      else if (!autofeed_out_n && ack_in_n)
      begin
         pd_in <= nxt;
         busy_in <= 1'h1;
         ack_in_n <= 1'h0;
      end
      else if (autofeed_out_n && !ack_in_n)
      begin
         ack_in_n <= 1'h1;
         nxt <= nxt + 8'h01;
         pd_in <= ~nxt;
      end
   end
endmodule

// file: dv/tb_parallel_port_ecp_mode_control.sv
`timescale 1ns/100ps
module tb_parallel_port_ecp_mode_control;
   typedef struct {logic w; logic [10:0] a; logic [7:0] d;} ppecp_row_t;
   logic       sys_clk_in = 1'h0, rst_in = 1'h1, io_cs_n_in = 1'h1, io_a10_in = 1'h0;
   logic       io_rd_n_in = 1'h1, io_wr_n_in = 1'h1, dma_ack_n_in = 1'h1, dma_tc_in = 1'h0;
   logic       fault_in_n = 1'h1, select_in = 1'h1, perror_in = 1'h0, rev_in = 1'h0;
   logic       fwd_ok = 1'h0, rev_ok = 1'h0, io_data_oe_out, dma_req_out, irq_out, irq_oe_out;
   logic       pd_oe_out, strobe_out_n, strobe_oe_out, autofeed_out_n, autofeed_oe_out;
   logic       init_out_n, init_oe_out, select_in_out_n, select_in_oe_out, busy_in, ack_in_n;
   logic [1:0] io_addr_in = 2'h0;
   logic [3:0] fifo_threshold_in = 4'h7;
   logic [7:0] io_data_in = 8'h00, io_data_out, pd_in, pd_out, q;
   int         error_cnt = 0, check_count = 0;
   wire  [2:0] ev = {rev_ok, fwd_ok, irq_oe_out};
   ppecp_row_t rows[13] = '{'{1'h0, 11'h402, 8'h15}, '{1'h1, 11'h402, 8'hd4},
      '{1'h0, 11'h402, 8'hd5}, '{1'h1, 11'h400, 8'h44}, '{1'h0, 11'h402, 8'hd4},
      '{1'h0, 11'h400, 8'h44}, '{1'h0, 11'h402, 8'hd5}, '{1'h1, 11'h402, 8'h34},
      '{1'h1, 11'h402, 8'hf4}, '{1'h0, 11'h400, 8'h10}, '{1'h1, 11'h402, 8'h74},
      '{1'h0, 11'h402, 8'hf5}, '{1'h1, 11'h402, 8'h14}};
   ppecp_port    i_dut (.*);
   ppecp_printer i_prn (.*);
   always #2 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
   begin
      fwd_ok <= i_prn.got.size() == 2;
      rev_ok <= i_prn.nxt == 8'hb0;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      check_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Pins pass two sync flops, so every phase is held several cycles
   task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      io_cs_n_in <= 1'h0;
      io_a10_in <= a[10];
      io_addr_in <= a[1:0];
      io_data_in <= d;
      io_wr_n_in <= !w;
      io_rd_n_in <= w;
      repeat (6) @(posedge sys_clk_in);
      q = io_data_out;
      io_wr_n_in <= 1'h1;
      io_rd_n_in <= 1'h1;
      repeat (4) @(posedge sys_clk_in);
      io_cs_n_in <= 1'h1;
      repeat (4) @(posedge sys_clk_in);
   endtask
   task automatic await(input int k);
      for (int n = 0; ev[k] !== 1'h1; n++)
      begin
         if (n == 3000)
         begin
            error_cnt++;
            end_of_test();
         end
         @(posedge sys_clk_in);
      end
      chk(ev[k], 1'h1);
   endtask
   initial
   begin
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      foreach (rows[i])
      begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk(q, rows[i].d);
      end
      $display("register table done");
      bus(1'h1, 11'h402, 8'hd4);
      for (int i = 0; i < 17; i++)
         bus(1'h1, 11'h400, i[7:0]);
      bus(1'h0, 11'h402, 8'h00);
      chk(q, 8'hd6);
      for (int i = 0; i < 17; i++)
      begin
         bus(1'h0, 11'h400, 8'h00);
         chk(q, (i == 16) ? 8'h0f : i[7:0]);
      end
      chk(9'(i_prn.got.size()), 9'h000);
      bus(1'h1, 11'h402, 8'hd0);
      chk(irq_oe_out, 1'h1);
      bus(1'h0, 11'h402, 8'h00);
      chk(q, 8'hd5);
      bus(1'h1, 11'h402, 8'hc8);
      chk(dma_req_out, 1'h1);
      dma_ack_n_in <= 1'h0;
      dma_tc_in <= 1'h1;
      bus(1'h1, 11'h400, 8'h33);
      chk(irq_oe_out, 1'h1);
      chk(dma_req_out, 1'h0);
      dma_ack_n_in <= 1'h1;
      dma_tc_in <= 1'h0;
      $display("fifo and service done");
      bus(1'h1, 11'h402, 8'h14);
      fault_in_n <= 1'h0;
      bus(1'h1, 11'h002, 8'h00);
      bus(1'h1, 11'h402, 8'h74);
      chk(irq_oe_out, 1'h0);
      bus(1'h1, 11'h402, 8'h64);
      chk(irq_oe_out, 1'h1);
      repeat (30) @(posedge sys_clk_in);
      fault_in_n <= 1'h1;
      repeat (8) @(posedge sys_clk_in);
      fault_in_n <= 1'h0;
      await(0);
      fault_in_n <= 1'h1;
      $display("fault done");
      bus(1'h1, 11'h400, 8'h5a);
      bus(1'h1, 11'h000, 8'h81);
      await(1);
      chk(i_prn.got[0], 9'h15a);
      chk(i_prn.got[1], 9'h081);
      bus(1'h0, 11'h402, 8'h00);
      chk(q, 8'h65);
      bus(1'h1, 11'h402, 8'h34);
      chk({strobe_out_n, autofeed_out_n}, 2'h3);
      bus(1'h1, 11'h402, 8'h54);
      bus(1'h1, 11'h400, 8'h3c);
      repeat (300) @(posedge sys_clk_in);
      chk(i_prn.got[2], 9'h13c);
      bus(1'h1, 11'h402, 8'h34);
      $display("forward done");
      bus(1'h1, 11'h002, 8'h20);
      rev_in <= 1'h1;
      bus(1'h1, 11'h402, 8'h74);
      await(2);
      bus(1'h0, 11'h402, 8'h00);
      chk(q, 8'h76);
      for (int i = 0; i < 2; i++)
      begin
         bus(1'h0, 11'h400, 8'h00);
         chk(q, 8'ha0 + i[7:0]);
      end
      bus(1'h1, 11'h402, 8'h34);
      bus(1'h0, 11'h402, 8'h00);
      chk(q, 8'h35);
      chk(autofeed_out_n, 1'h1);
      rev_in <= 1'h0;
      bus(1'h1, 11'h002, 8'h00);
      $display("reverse done");
      end_of_test();
   end
endmodule
